// *** pstc_pkg.sv ***
// shared constants and carriers for the pixel sample timing control block
`default_nettype none
package pstc_pkg;

	// ********************************************************
	// colour codes shared by the multiplexers
	// ********************************************************
	localparam logic [1:0] PSTC_RED = 2'h0;
	localparam logic [1:0] PSTC_GREEN = 2'h1;
	localparam logic [1:0] PSTC_BLUE = 2'h2;

	// ********************************************************
	// sizes, counts and reset values
	// ********************************************************
	localparam int PSTC_DELAY_W = 3;
	localparam int PSTC_NUM_BLOCKS = 4;
	localparam int PSTC_NUM_CHAN = 3;
	// cycles taken to stream the three parallel samples out
	localparam int PSTC_STREAM_LEN = 3;
	// partner-side limits, kept for reference only
	localparam int PSTC_MCLK_MAX_MHZ = 40;
	localparam int PSTC_SYNC_MAX_MHZ = 20;
	localparam logic [3:0] PSTC_RST_BLOCK_EN = 4'h0;
	localparam logic [2:0] PSTC_RST_CHAN_EN = 3'h0;
	localparam logic [2:0] PSTC_ALL_CHAN = 3'h7;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef struct packed {
		logic [3:0] block_en;
		logic [2:0] chan_en;
		logic active;
	} pstc_pwr_s;

	typedef struct packed {
		logic [1:0] input_sel;
		logic [1:0] coeff_sel;
	} pstc_sel_s;

	typedef enum logic [1:0] {
		STR_IDLE,
		STR_RED,
		STR_GREEN,
		STR_BLUE
	} pstc_stream_e;

	function automatic logic [1:0] pstc_next_colour(input logic [1:0] c);
		case (c)
			PSTC_RED: pstc_next_colour = PSTC_GREEN;
			PSTC_GREEN: pstc_next_colour = PSTC_BLUE;
			default: pstc_next_colour = PSTC_RED;
		endcase
	endfunction : pstc_next_colour

	function automatic logic [2:0] pstc_onehot(input logic [1:0] c);
		case (c)
			PSTC_RED: pstc_onehot = 3'h1;
			PSTC_GREEN: pstc_onehot = 3'h2;
			PSTC_BLUE: pstc_onehot = 3'h4;
			default: pstc_onehot = 3'h0;
		endcase
	endfunction : pstc_onehot

endpackage : pstc_pkg
`default_nettype wire

// *** pstc_top.sv ***
// pixel sample timing control: sync detect, sampling strobe, power and colour muxes
//
// Notes on behaviour
// (R1) partner master clock 40MHz, sync 20MHz max
// (R2) partner pin sync pulse lasts one clock
// (R3) sample on first edge after sync low
// (R4) detector makes pulse from chosen sync edge
// (R5) internal pulse delayed by sync_delay clocks
// (R6) detector pulse replaces pin pulse when enabled
// (R7) global enable powers whole device down/up; the code ignores global_en while selective_pd_en is set
// (R8) selective mode: mask bits disable blocks
// (R9) state kept and controls live when down
// (R10) line mode: green/blue off, red only
// (R11) single mode samples input_channel_sel input
// (R12) muxes advance first edge after pulse high
// (R13) autocycle reset write selects red everywhere; with force on, the input mux keeps forced_input_sel
// (R14) no force, no pin: all follow colour field
// (R15) no force, pin: all cycle together
// (R16) force, no pin: input forced, coeff field
// (R17) force, pin: input forced, coeff cycles
// (R18) partner keeps clock-to-sync ratio per mode
// (R19) interleaved: three parallel samples streamed out
// (R20) software programs setup register per mode
// (R21) detector compares registered sync with previous
`timescale 1ns/1ps
`default_nettype none
module pstc_top
	import pstc_pkg::*;
#(
	parameter int DELAY_W = PSTC_DELAY_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pixel_sync,
	input wire logic autocycle_pulse_pin,
	input wire logic global_en,
	input wire logic selective_pd_en,
	input wire logic [3:0] block_disable_mask,
	input wire logic sync_detect_en,
	input wire logic sync_edge_pol,
	input wire logic [DELAY_W-1:0] sync_delay,
	input wire logic line_seq_colour_en,
	input wire logic single_channel_mode,
	input wire logic [1:0] input_channel_sel,
	input wire logic autocycle_pin_en,
	input wire logic force_mux_en,
	input wire logic [1:0] forced_input_sel,
	input wire logic [1:0] internal_colour_sel,
	input wire logic autocycle_reset_wr,
	output logic sample_strobe,
	output logic [2:0] sample_chan_en,
	output logic stream_valid,
	output logic [1:0] stream_colour,
	output pstc_sel_s sel,
	output pstc_pwr_s pwr
);

	localparam int HIST = (1 << DELAY_W) - 1;

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	initial begin
		if (DELAY_W < 2 || DELAY_W > 4) $error("pstc_top: DELAY_W must be 2..4");
	end

	// ********************************************************
	// pin synchronisers
	// ********************************************************
	logic sync_m, sync_s, sync_prev;
	logic acyc_m, acyc_s, acyc_prev;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync_m <= 1'b0;
			sync_s <= 1'b0;
			sync_prev <= 1'b0;
			acyc_m <= 1'b0;
			acyc_s <= 1'b0;
			acyc_prev <= 1'b0;
		end else begin
			sync_m <= pixel_sync;
			sync_s <= sync_m;
			sync_prev <= sync_s; // R21
			acyc_m <= autocycle_pulse_pin;
			acyc_s <= acyc_m;
			acyc_prev <= acyc_s;
		end
	end

	// ********************************************************
	// programmable sync edge detector and delay
	// ********************************************************
	logic edge_pulse;
	logic int_pulse;
	logic [HIST-1:0] hist;

	// a shift history rather than a counter, so edges closer together
	// than the delay are each kept
	assign edge_pulse = sync_detect_en &&
		(sync_edge_pol ? (sync_s && !sync_prev) : (!sync_s && sync_prev)); // R4 R21

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hist <= '0;
		end else begin
			hist <= {hist[HIST-2:0], edge_pulse}; // R5
		end
	end

	always_comb begin
		if (sync_delay == '0) begin
			int_pulse = edge_pulse;
		end else begin
			int_pulse = hist[sync_delay - 1'b1]; // R5
		end
	end

	// ********************************************************
	// power control
	// ********************************************************
	logic dev_active;
	logic single_eff;

	assign dev_active = selective_pd_en ? 1'b1 : global_en; // R7 R8
	assign single_eff = line_seq_colour_en || single_channel_mode; // R10

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pwr.block_en <= PSTC_RST_BLOCK_EN;
			pwr.chan_en <= PSTC_RST_CHAN_EN;
			pwr.active <= 1'b0;
		end else begin
			if (selective_pd_en) begin
				pwr.block_en <= ~block_disable_mask; // R8
			end else begin
				pwr.block_en <= {PSTC_NUM_BLOCKS{global_en}}; // R7
			end
			if (!dev_active) begin
				pwr.chan_en <= 3'h0;
			end else if (line_seq_colour_en) begin
				pwr.chan_en <= 3'h1; // R10
			end else begin
				pwr.chan_en <= PSTC_ALL_CHAN;
			end
			pwr.active <= dev_active;
		end
	end

	// ********************************************************
	// sampling strobe
	// ********************************************************
	logic eff_sync;
	logic eff_prev;
	logic take_sample;
	logic [1:0] next_input;
	logic [1:0] next_coeff;

	assign eff_sync = sync_detect_en ? int_pulse : sync_s; // R6
	assign take_sample = eff_prev && !eff_sync && dev_active; // R3 R6

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			eff_prev <= 1'b0;
		end else begin
			eff_prev <= eff_sync;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sample_strobe <= 1'b0;
			sample_chan_en <= 3'h0;
		end else begin
			sample_strobe <= take_sample; // R3
			if (take_sample) begin
				// R11 R19
				sample_chan_en <= line_seq_colour_en ? 3'h1 // R10
					: (single_eff ? pstc_onehot(next_input) : PSTC_ALL_CHAN);
			end else begin
				sample_chan_en <= 3'h0;
			end
		end
	end

	// ********************************************************
	// auto-cycle colour state
	// ********************************************************
	logic [1:0] cyc_colour;
	logic acyc_rise;

	assign acyc_rise = acyc_s && !acyc_prev;

	// not reset by power-down, so the colour survives standby
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cyc_colour <= PSTC_RED;
		end else if (autocycle_reset_wr) begin
			cyc_colour <= PSTC_RED; // R13 R9
		end else if (acyc_rise && autocycle_pin_en) begin
			cyc_colour <= pstc_next_colour(cyc_colour); // R12 R15 R17
		end
	end

	// ********************************************************
	// interleaved stream of the three parallel samples
	// ********************************************************
	function automatic logic [1:0] stream_colour_of(input pstc_stream_e s);
		case (s)
			STR_GREEN: stream_colour_of = PSTC_GREEN;
			STR_BLUE: stream_colour_of = PSTC_BLUE;
			default: stream_colour_of = PSTC_RED;
		endcase
	endfunction : stream_colour_of

	pstc_stream_e str_state;
	pstc_stream_e next_str;

	always_comb begin
		next_str = str_state;
		case (str_state)
			STR_IDLE: begin
				if (take_sample && !single_eff) begin
					next_str = STR_RED; // R19
				end
			end
			STR_RED: next_str = STR_GREEN;
			STR_GREEN: next_str = STR_BLUE;
			STR_BLUE: begin
				if (take_sample && !single_eff) begin
					next_str = STR_RED;
				end else begin
					next_str = STR_IDLE;
				end
			end
			default: next_str = STR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			str_state <= STR_IDLE;
		end else begin
			str_state <= next_str;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stream_valid <= 1'b0;
			stream_colour <= PSTC_RED;
		end else begin
			stream_valid <= (next_str != STR_IDLE); // R19
			stream_colour <= stream_colour_of(next_str); // R19
		end
	end

	// ********************************************************
	// input and coefficient multiplexers
	// ********************************************************
	always_comb begin
		if (line_seq_colour_en) begin
			if (force_mux_en) begin
				next_input = forced_input_sel; // R16 R17
			end else if (autocycle_pin_en) begin
				next_input = cyc_colour; // R15
			end else begin
				next_input = internal_colour_sel; // R14
			end
			next_coeff = autocycle_pin_en ? cyc_colour : internal_colour_sel; // R14 R15
		end else if (single_channel_mode) begin
			next_input = input_channel_sel; // R11
			next_coeff = input_channel_sel;
		end else begin
			next_input = PSTC_RED;
			next_coeff = stream_colour_of(next_str);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sel.input_sel <= PSTC_RED;
			sel.coeff_sel <= PSTC_RED;
		end else begin
			sel.input_sel <= next_input;
			sel.coeff_sel <= next_coeff;
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	sequence s_sync_fall;
		eff_prev && !eff_sync && dev_active;
	endsequence
	sequence s_edge_delay3;
		(edge_pulse && sync_delay == 3) ##1 (sync_delay == 3) [*3];
	endsequence
	property p_sample_after_fall;
		s_sync_fall |=> sample_strobe;
	endproperty
	a_sample_after_fall: assert property (p_sample_after_fall) // R3
		else $error("no sample after sync fall");
	property p_strobe_cause;
		sample_strobe |-> $past(eff_prev) && !$past(eff_sync);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) // R6
		else $error("sample strobe without a sync fall");
	property p_edge_detect;
		(sync_detect_en && sync_edge_pol && sync_s && !sync_prev) |=> hist[0];
	endproperty
	a_edge_detect: assert property (p_edge_detect) // R4
		else $error("rising sync edge not detected");
	property p_delay3;
		s_edge_delay3 |-> int_pulse;
	endproperty
	a_delay3: assert property (p_delay3) // R5
		else $error("internal pulse not delayed by three");
	property p_pd_global;
		(!selective_pd_en && !global_en) |=> pwr.block_en == 4'h0 && pwr.chan_en == 3'h0;
	endproperty
	a_pd_global: assert property (p_pd_global) // R7
		else $error("global power down not applied");
	property p_pd_select;
		selective_pd_en |=> pwr.block_en == ~$past(block_disable_mask) && pwr.active;
	endproperty
	a_pd_select: assert property (p_pd_select) // R8
		else $error("selective power mask not applied");
	property p_line_seq_red;
		line_seq_colour_en |=> pwr.chan_en[2:1] == 2'h0 && sample_chan_en[2:1] == 2'h0;
	endproperty
	a_line_seq_red: assert property (p_line_seq_red) // R10
		else $error("green or blue powered in line mode");
	property p_single_sel;
		(single_channel_mode && !line_seq_colour_en) |=> sel.input_sel == $past(input_channel_sel);
	endproperty
	a_single_sel: assert property (p_single_sel) // R11
		else $error("single mode input not followed");
	property p_acyc_adv;
		(acyc_rise && autocycle_pin_en && !autocycle_reset_wr && cyc_colour == PSTC_BLUE)
			|=> cyc_colour == PSTC_RED;
	endproperty
	a_acyc_adv: assert property (p_acyc_adv) // R15
		else $error("auto-cycle did not wrap to red");
	property p_acyc_reset;
		autocycle_reset_wr ##1 (line_seq_colour_en && autocycle_pin_en && !force_mux_en
			&& !autocycle_reset_wr) |=> sel.input_sel == PSTC_RED && sel.coeff_sel == PSTC_RED;
	endproperty
	a_acyc_reset: assert property (p_acyc_reset) // R13
		else $error("auto-cycle reset did not select red");
	property p_force;
		(line_seq_colour_en && force_mux_en && !autocycle_pin_en)
			|=> sel.input_sel == $past(forced_input_sel)
			&& sel.coeff_sel == $past(internal_colour_sel);
	endproperty
	a_force: assert property (p_force) // R16
		else $error("forced input mux wrong");
	property p_interleave;
		(take_sample && !single_eff) |=> stream_valid [*3];
	endproperty
	a_interleave: assert property (p_interleave) // R19
		else $error("three-sample stream not produced");

endmodule : pstc_top
`default_nettype wire

// *** pstc_ctrl_model.sv ***
// scanner controller model driving the pixel sync and auto-cycle pins
`timescale 1ns/1ps
`default_nettype none
module pstc_ctrl_model (
	input wire logic clk_sys,
	output var logic pixel_sync,
	output var logic autocycle_pulse_pin
);
	// pins rest low between pulses
	initial begin
		pixel_sync = 1'b0;
		autocycle_pulse_pin = 1'b0;
	end

	// hi of 1 is the plain one-clock pulse; longer holds mimic a shift clock
	// callers leave at least 40 clocks between rises, beyond any mode ratio
	task automatic sync_pulse(input int hi);
		pixel_sync = 1'b1;
		repeat (hi) @(posedge clk_sys);
		#1;
		pixel_sync = 1'b0;
	endtask : sync_pulse

	task automatic cyc_pulse();
		autocycle_pulse_pin = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		autocycle_pulse_pin = 1'b0;
	endtask : cyc_pulse
endmodule : pstc_ctrl_model
`default_nettype wire

// *** pixel_sample_timing_control_tb.sv ***
// self-checking bench for the pixel sample timing control block
`timescale 1ns/1ps
`default_nettype none
module pixel_sample_timing_control_tb;
	import pstc_pkg::*;
	logic clk_sys, resetn, pixel_sync, autocycle_pulse_pin, global_en, selective_pd_en;
	logic sync_detect_en, sync_edge_pol, line_seq_colour_en, single_channel_mode;
	logic autocycle_pin_en, force_mux_en, autocycle_reset_wr;
	logic [3:0] block_disable_mask;
	logic [2:0] sync_delay, sample_chan_en, en;
	logic [1:0] input_channel_sel, forced_input_sel, internal_colour_sel, stream_colour;
	logic sample_strobe, stream_valid;
	pstc_sel_s sel;
	pstc_pwr_s pwr;
	logic [1:0] seen_q[$];
	int failures = 0, num_checks = 0, cycles = 0, lat, n, base;

	pstc_top pstc_top_inst (.clk_sys(clk_sys), .resetn(resetn), .pixel_sync(pixel_sync),
		.autocycle_pulse_pin(autocycle_pulse_pin), .global_en(global_en),
		.selective_pd_en(selective_pd_en), .block_disable_mask(block_disable_mask),
		.sync_detect_en(sync_detect_en), .sync_edge_pol(sync_edge_pol),
		.sync_delay(sync_delay), .line_seq_colour_en(line_seq_colour_en),
		.single_channel_mode(single_channel_mode), .input_channel_sel(input_channel_sel),
		.autocycle_pin_en(autocycle_pin_en), .force_mux_en(force_mux_en),
		.forced_input_sel(forced_input_sel), .internal_colour_sel(internal_colour_sel),
		.autocycle_reset_wr(autocycle_reset_wr), .sample_strobe(sample_strobe),
		.sample_chan_en(sample_chan_en), .stream_valid(stream_valid),
		.stream_colour(stream_colour), .sel(sel), .pwr(pwr));
	pstc_ctrl_model pstc_ctrl_model_inst (.clk_sys(clk_sys), .pixel_sync(pixel_sync),
		.autocycle_pulse_pin(autocycle_pulse_pin));

	// ********************************************************
	// clock, timeout and reporting
	// ********************************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick

	// ********************************************************
	// sync pulse with strobe and stream watch
	// ********************************************************
	// latency counts edges from the rise; strobes and stream colours are collected
	task automatic measure(input int hi);
		lat = -1;
		n = 0;
		en = 3'h0;
		seen_q = {};
		fork
			pstc_ctrl_model_inst.sync_pulse(hi);
			for (int i = 1; i <= 40; i++) begin
				tick(1);
				if (stream_valid === 1'b1) seen_q.push_back(stream_colour);
				if (sample_strobe === 1'b1) begin
					if (lat < 0) lat = i;
					if (lat == i) en = sample_chan_en;
					n++;
				end
			end
		join
	endtask : measure

	task automatic check_sel(input logic [1:0] in_exp, input logic [1:0] co_exp);
		check("sel.input_sel", sel.input_sel, in_exp);
		check("sel.coeff_sel", sel.coeff_sel, co_exp);
	endtask : check_sel

	task automatic ac_reset();
		autocycle_reset_wr = 1'b1;
		tick(1);
		autocycle_reset_wr = 1'b0;
		tick(3);
	endtask : ac_reset

	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		{resetn, selective_pd_en, sync_detect_en, sync_edge_pol, line_seq_colour_en} = 5'h00;
		{single_channel_mode, autocycle_pin_en, force_mux_en, autocycle_reset_wr} = 4'h0;
		{block_disable_mask, sync_delay, input_channel_sel} = 9'h000;
		{forced_input_sel, internal_colour_sel} = 4'h0;
		global_en = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		tick(3);
		check("pwr", pwr, {4'hF, PSTC_ALL_CHAN, 1'b1});
		measure(1);
		check("strobes", n, 1);
		check("strobe latency", lat, 4);
		check("sample_chan_en", en, PSTC_ALL_CHAN);
		check("stream length", seen_q.size(), PSTC_STREAM_LEN);
		for (int c = 0; c < 3; c++) check("stream_colour", seen_q[c], c);
		// detector: edge-to-edge spacing must show up exactly in the latency
		sync_detect_en = 1'b1;
		sync_edge_pol = 1'b1;
		measure(10);
		base = lat;
		check("detector strobes", n, 1);
		sync_edge_pol = 1'b0;
		measure(10);
		check("falling edge latency", lat, base + 10);
		check("detector strobes", n, 1);
		sync_edge_pol = 1'b1;
		for (int d = 3; d <= 7; d += 2) begin
			sync_delay = 3'(d);
			measure(10);
			check("delayed latency", lat, base + d);
		end
		sync_detect_en = 1'b0;
		global_en = 1'b0;
		tick(3);
		check("pwr down", pwr, 8'h00);
		measure(1);
		check("strobes when down", n, 0);
		selective_pd_en = 1'b1;
		block_disable_mask = 4'h5;
		tick(3);
		check("block_en", pwr.block_en, 4'hA);
		global_en = 1'b1;
		tick(3);
		check("block_en", pwr.block_en, 4'hA);
		{selective_pd_en, block_disable_mask} = 5'h00;
		single_channel_mode = 1'b1;
		for (int c = 0; c < 3; c++) begin
			input_channel_sel = 2'(c);
			tick(2);
			measure(1);
			check("single chan_en", en, 3'h1 << c);
		end
		single_channel_mode = 1'b0;
		line_seq_colour_en = 1'b1;
		tick(3);
		check("line chan power", pwr.chan_en, 3'h1);
		measure(1);
		check("line chan_en", en, 3'h1);
		for (int c = 0; c < 3; c++) begin
			internal_colour_sel = 2'(c);
			tick(2);
			check_sel(2'(c), 2'(c));
		end
		force_mux_en = 1'b1;
		forced_input_sel = PSTC_BLUE;
		internal_colour_sel = PSTC_GREEN;
		tick(2);
		check_sel(PSTC_BLUE, PSTC_GREEN);
		force_mux_en = 1'b0;
		autocycle_pin_en = 1'b1;
		ac_reset();
		check_sel(PSTC_RED, PSTC_RED);
		for (int k = 1; k <= 3; k++) begin
			pstc_ctrl_model_inst.cyc_pulse();
			tick(4);
			check_sel(2'(k % 3), 2'(k % 3));
			if (k == 1) begin
				global_en = 1'b0;
				tick(3);
				global_en = 1'b1;
				tick(2);
				check_sel(PSTC_GREEN, PSTC_GREEN);
			end
		end
		force_mux_en = 1'b1;
		ac_reset();
		pstc_ctrl_model_inst.cyc_pulse();
		tick(4);
		check_sel(PSTC_BLUE, PSTC_GREEN);
		ac_reset();
		check_sel(PSTC_BLUE, PSTC_RED);
		give_verdict();
	end
endmodule : pixel_sample_timing_control_tb
`default_nettype wire
